// ### rtl/adc_conversion_control.sv
// Control logic around a 12-bit successive-conversion converter: clock divider,
// power, source routing, start pulse, 16-cycle timing, busy, flag and results.
// Assumes synchronous register port and an analog core that returns its result bits serially.
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"
module adc_conversion_control (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire adc_ctrl_pkg::reg_req_t req_i,
  output logic [7:0] rdata_o,
  input wire logic cmp_bit_i,
  output logic conv_clock_o,
  output logic converter_power_enable_o,
  output logic sample_o,
  output logic core_reset_o,
  output adc_ctrl_pkg::analog_route_t route_o,
  output logic irq_o
);
  logic [7:0] converter_control_reg_a;
  logic [7:0] converter_control_reg_b;
  logic [7:0] converter_control_reg_c;
  logic global_irq_enable;
  logic conversion_irq_enable;
  logic conversion_irq_flag;
  logic conversion_busy_flag;
  logic [7:0] result_high_byte;
  logic [7:0] result_low_byte;
  logic [11:0] shift;
  logic [6:0] div_cnt;
  logic [4:0] tick_cnt;
  logic start_seen_low;
  adc_ctrl_pkg::conv_state_t state;
  adc_ctrl_pkg::conv_state_t next_state;

  function automatic logic hit(input adc_ctrl_pkg::reg_req_t r, input logic [2:0] a);
    return r.wr && (r.addr == a);
  endfunction : hit

  // External sources: codes 0000, 0100 and 11xx
  function automatic logic is_ext_source(input logic [3:0] code);
    return (code == 4'h0) || (code == 4'h4) || (code[3:2] == 2'b11);
  endfunction : is_ext_source

  wire converter_power_enable = converter_control_reg_a[`A_PWR_BIT];
  wire start_bit = converter_control_reg_a[`A_START_BIT];
  wire [3:0] external_channel_select = converter_control_reg_a[3:0];
  wire [3:0] input_source_select = converter_control_reg_b[7:4];
  wire result_format_select = converter_control_reg_b[`B_FMT_BIT];
  wire [2:0] conv_clock_divider_select = converter_control_reg_b[2:0];
  wire [1:0] reference_source_select = converter_control_reg_c[`C_REF_LSB+1:`C_REF_LSB];
  wire wr_a = hit(req_i, `REG_A_ADDR);
  wire wr_irq = hit(req_i, `IRQ_CTRL_ADDR);
  wire [7:0] next_a = wr_a ? req_i.wdata : converter_control_reg_a;
  wire next_start = next_a[`A_START_BIT];
  wire [6:0] div_mask = 7'(({7'h00, 1'b1} << conv_clock_divider_select) - 8'h01);
  wire adc_tick = (div_cnt & div_mask) == div_mask;
  wire [6:0] next_div = 7'(div_cnt + 7'h01);
  wire next_clk = (conv_clock_divider_select == 3'h0) ? 1'b1 : next_div[conv_clock_divider_select - 3'h1];
  wire ext_source = is_ext_source(input_source_select);
  wire ext_connect = ext_source && !external_channel_select[3];
  wire conv_done = (state == adc_ctrl_pkg::ST_CONVERT) && adc_tick &&
                   (tick_cnt == `TOTAL_CYCLES - 5'd1);
  wire [11:0] result = {shift[10:0], cmp_bit_i} & `FULL_SCALE;
  wire [7:0] next_hi = result_format_select ? {4'h0, result[11:8]} : result[11:4];
  wire [7:0] next_lo = result_format_select ? result[7:0] : {result[3:0], 4'h0};
  wire [7:0] irq_rd = {5'h00, conversion_irq_flag, conversion_irq_enable, global_irq_enable};
  wire [7:0] a_rd = {converter_control_reg_a[7], conversion_busy_flag, converter_control_reg_a[5:0]};
  wire [7:0] next_rdata = !req_i.rd ? 8'h00 :
                          (req_i.addr == `REG_A_ADDR) ? a_rd :
                          (req_i.addr == `REG_B_ADDR) ? converter_control_reg_b :
                          (req_i.addr == `REG_C_ADDR) ? converter_control_reg_c :
                          (req_i.addr == `RES_HI_ADDR) ? result_high_byte :
                          (req_i.addr == `RES_LO_ADDR) ? result_low_byte :
                          (req_i.addr == `IRQ_CTRL_ADDR) ? irq_rd : 8'h00;

  always_comb begin
    next_state = state;
    case (state)
      adc_ctrl_pkg::ST_IDLE: begin
        // pulse needs prior low and power
        if (start_bit && start_seen_low && converter_power_enable) begin
          next_state = adc_ctrl_pkg::ST_ARMED;
        end
      end
      adc_ctrl_pkg::ST_ARMED: begin
        if (!start_bit) begin
          next_state = adc_ctrl_pkg::ST_SAMPLE;
        end
      end
      adc_ctrl_pkg::ST_SAMPLE: begin
        if (adc_tick && tick_cnt == `SAMPLE_CYCLES - 5'd1) begin
          next_state = adc_ctrl_pkg::ST_CONVERT;
        end
      end
      adc_ctrl_pkg::ST_CONVERT: begin
        if (conv_done) begin
          next_state = adc_ctrl_pkg::ST_IDLE;
        end
      end
      default: next_state = adc_ctrl_pkg::ST_IDLE;
    endcase
    if (!converter_power_enable) begin
      next_state = adc_ctrl_pkg::ST_IDLE;
    end
    if (start_bit && (state == adc_ctrl_pkg::ST_SAMPLE || state == adc_ctrl_pkg::ST_CONVERT)) begin
      next_state = adc_ctrl_pkg::ST_ARMED;
    end
  end

  // Control A follows the bus mux every cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      converter_control_reg_a <= `REG_A_RST;
    end else begin
      converter_control_reg_a <= next_a;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      converter_control_reg_b <= `REG_B_RST;
    end else if (hit(req_i, `REG_B_ADDR)) begin
      converter_control_reg_b <= req_i.wdata;
    end
  end

  // Unused bits of control C are kept for read back
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      converter_control_reg_c <= `REG_C_RST;
    end else if (hit(req_i, `REG_C_ADDR)) begin
      converter_control_reg_c <= req_i.wdata;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      global_irq_enable <= 1'b0;
      conversion_irq_enable <= 1'b0;
    end else if (wr_irq) begin
      global_irq_enable <= req_i.wdata[`IRQ_GIE_BIT];
      conversion_irq_enable <= req_i.wdata[`IRQ_ADE_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      start_seen_low <= 1'b0;
    end else begin
      start_seen_low <= (state == adc_ctrl_pkg::ST_IDLE) ? (start_seen_low || !next_start) : 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      state <= adc_ctrl_pkg::ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Divider restarts at every launch so the first tick is a full period
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= 7'h00;
    end else begin
      div_cnt <= (state == adc_ctrl_pkg::ST_SAMPLE || state == adc_ctrl_pkg::ST_CONVERT) ?
                 next_div : 7'h00;
    end
  end

  // Tick count runs on through sampling into converting
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      tick_cnt <= 5'd0;
    end else if (next_state != state && next_state != adc_ctrl_pkg::ST_CONVERT) begin
      tick_cnt <= 5'd0;
    end else if (adc_tick && state != adc_ctrl_pkg::ST_IDLE && state != adc_ctrl_pkg::ST_ARMED) begin
      tick_cnt <= 5'(tick_cnt + 5'd1);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      shift <= 12'h000;
    end else if (state == adc_ctrl_pkg::ST_CONVERT && adc_tick) begin
      shift <= {shift[10:0], cmp_bit_i};
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      conversion_busy_flag <= 1'b0;
    end else begin
      conversion_busy_flag <= (next_state == adc_ctrl_pkg::ST_SAMPLE) ||
                              (next_state == adc_ctrl_pkg::ST_CONVERT);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      conversion_irq_flag <= 1'b0;
    end else if (conv_done) begin
      conversion_irq_flag <= 1'b1;
    end else if (wr_irq) begin
      conversion_irq_flag <= req_i.wdata[`IRQ_FLAG_BIT];
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      result_high_byte <= 8'h00;
      result_low_byte <= 8'h00;
    end else if (conv_done && converter_power_enable) begin
      result_high_byte <= next_hi;
      result_low_byte <= next_lo;
    end
  end

  // Read data stand for one cycle only
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else begin
      rdata_o <= next_rdata;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      conv_clock_o <= 1'b0;
    end else begin
      conv_clock_o <= (next_state == adc_ctrl_pkg::ST_SAMPLE || next_state == adc_ctrl_pkg::ST_CONVERT) &&
                      next_clk && (state != adc_ctrl_pkg::ST_IDLE);
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      converter_power_enable_o <= 1'b0;
    end else begin
      converter_power_enable_o <= converter_power_enable;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      sample_o <= 1'b0;
    end else begin
      sample_o <= next_state == adc_ctrl_pkg::ST_SAMPLE;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      core_reset_o <= 1'b0;
    end else begin
      core_reset_o <= next_state == adc_ctrl_pkg::ST_ARMED;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      route_o <= '0;
    end else begin
      route_o.ext_enable <= ext_connect && converter_power_enable;
      route_o.ext_channel <= external_channel_select[2:0];
      route_o.internal_source <= ext_source ? 4'h0 : input_source_select;
      route_o.reference <= reference_source_select;
    end
  end

  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= conversion_irq_flag && global_irq_enable && conversion_irq_enable;
    end
  end
endmodule : adc_conversion_control

// ### rtl/adc_ctrl_cfg.svh
// Constants of the converter control block: register offsets, field positions, resets, timing.
// Assumes inclusion by bare name from the package and the design file.
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

`define ADDR_W 3
`define REG_A_ADDR 3'h0
`define REG_B_ADDR 3'h1
`define REG_C_ADDR 3'h2
`define RES_HI_ADDR 3'h3
`define RES_LO_ADDR 3'h4
`define IRQ_CTRL_ADDR 3'h5
`define REG_A_RST 8'h00
`define REG_B_RST 8'h00
`define REG_C_RST 8'h00
// Control A: start 7, busy 6 (read only), power enable 5, channel select 3:0
`define A_START_BIT 7
`define A_BUSY_BIT 6
`define A_PWR_BIT 5
// Control B: source select 7:4, format 3, divider select 2:0
`define B_FMT_BIT 3
// Control C: reference select 3:2
`define C_REF_LSB 2
// Irq control: global enable 0, converter enable 1, flag 2
`define IRQ_GIE_BIT 0
`define IRQ_ADE_BIT 1
`define IRQ_FLAG_BIT 2
`define SAMPLE_CYCLES 5'd4
`define CONVERT_CYCLES 5'd12
`define TOTAL_CYCLES 5'd16
`define FULL_SCALE 12'hfff

`endif

// ### rtl/adc_ctrl_pkg.sv
// Types of the converter control block.
// Assumes adc_ctrl_cfg.svh is on the include path.
`include "adc_ctrl_cfg.svh"
package adc_ctrl_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_ARMED = 4'b0010,
    ST_SAMPLE = 4'b0100,
    ST_CONVERT = 4'b1000
  } conv_state_t;

  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic ext_enable;
    logic [2:0] ext_channel;
    logic [3:0] internal_source;
    logic [1:0] reference;
  } analog_route_t;
endpackage : adc_ctrl_pkg

// ### tb/adc_conversion_control_monitor.sv
// Checker of the converter control block, bound to its top module.
// Assumes one-cycle write strobes and stable settings during a conversion.
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"
module adc_conversion_control_monitor (
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire adc_ctrl_pkg::reg_req_t req_i,
  input wire logic conv_clock_o,
  input wire logic converter_power_enable_o,
  input wire logic sample_o,
  input wire logic core_reset_o,
  input wire adc_ctrl_pkg::analog_route_t route_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  logic [7:0] b_q;
  logic [3:0] chan_q;
  logic [1:0] en_q;
  logic [11:0] cnt;
  logic smp_q;
  wire wr_a = req_i.wr && req_i.addr == `REG_A_ADDR;
  wire [3:0] src = b_q[7:4];
  wire ext_exp = (src == 4'h0 || src == 4'h4 || src[3:2] == 2'b11) && !chan_q[3];
  wire [4:0] rk = {ext_exp, chan_q};
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      b_q <= 8'h00;
      chan_q <= 4'h0;
      en_q <= 2'h0;
      cnt <= 12'h000;
      smp_q <= 1'b0;
    end else begin
      if (req_i.wr && req_i.addr == `REG_B_ADDR) b_q <= req_i.wdata;
      if (wr_a) chan_q <= req_i.wdata[3:0];
      if (req_i.wr && req_i.addr == `IRQ_CTRL_ADDR) en_q <= req_i.wdata[1:0];
      smp_q <= sample_o;
      cnt <= (sample_o && !smp_q) ? 12'h001 : cnt + 12'h001;
    end
  end
  a_power_follows: assert property (
    wr_a ##1 !wr_a |=> converter_power_enable_o == $past(req_i.wdata[`A_PWR_BIT], 2))
    else $error("power enable not following write");
  a_power_off_idle: assert property (
    !converter_power_enable_o && !$past(converter_power_enable_o) |-> !sample_o && !conv_clock_o)
    else $error("activity while powered down");
  a_sample_len: assert property (
    $fell(sample_o) && converter_power_enable_o && $past(converter_power_enable_o)
      |-> cnt == (12'h004 << b_q[2:0])) else $error("sample phase length wrong");
  a_conv_len: assert property (
    $rose(irq_o) && $past(en_q, 2) == 2'h3 |-> cnt >= (12'h010 << b_q[2:0])
      && cnt <= (12'h010 << b_q[2:0]) + 12'h003) else $error("conversion length wrong");
  a_irq_needs_en: assert property (
    irq_o |-> en_q == 2'h3 || $past(en_q) == 2'h3) else $error("interrupt while disabled");
  a_start_launch: assert property (
    $fell(core_reset_o) && converter_power_enable_o |-> ##[0:2] sample_o)
    else $error("no launch after start pulse");
  a_sample_after_rst: assert property (
    $rose(sample_o) |-> $past(core_reset_o) || $past(core_reset_o, 2))
    else $error("sampling without start pulse");
  a_route_ext: assert property (
    $past(rk) == rk && $past(rk, 2) == rk |->
      route_o.ext_enable == (ext_exp && converter_power_enable_o)
      && (!ext_exp || route_o.ext_channel == chan_q[2:0])) else $error("external routing wrong");
endmodule : adc_conversion_control_monitor
bind adc_conversion_control adc_conversion_control_monitor i_mon (.clk_sys_i(clk_sys_i),
  .rst_i(rst_i), .req_i(req_i), .conv_clock_o(conv_clock_o), .sample_o(sample_o),
  .converter_power_enable_o(converter_power_enable_o), .core_reset_o(core_reset_o),
  .route_o(route_o), .irq_o(irq_o));

// ### tb/adc_analog_model.sv
// Analog side: routed input level as seen by the comparator.
// Assumes every source sits at zero or full scale, so all result bits match.
`timescale 1ns/100ps
module adc_analog_model (
  input wire logic clk_sys_i,
  input wire logic pwr_i,
  input wire adc_ctrl_pkg::analog_route_t route_i,
  output logic cmp_bit_o
);
  logic idle_bit = 1'b0;
  wire gnd = route_i.internal_source[3:2] == 2'b10;
  wire lvl = route_i.ext_enable ? route_i.ext_channel[0] : route_i.internal_source[0] && !gnd;
  always @(posedge clk_sys_i) idle_bit <= !idle_bit;
  assign cmp_bit_o = pwr_i ? lvl : idle_bit;
endmodule : adc_analog_model

// ### tb/test_adc_conversion_control.sv
// Self-checking bench of the converter control block with the analog model.
// Assumes offsets and bit positions of the shared header.
`timescale 1ns/100ps
`include "adc_ctrl_cfg.svh"
module test_adc_conversion_control;
  logic clk_sys_i = 1'b0;
  logic rst_i = 1'b1;
  adc_ctrl_pkg::reg_req_t req = '0;
  adc_ctrl_pkg::analog_route_t route;
  logic [7:0] rdata;
  logic cmp_bit, conv_clk, pwr, smp, crst, irq;
  int err_count = 0;
  int comparisons = 0;
  int seed = 40564;
  logic [7:0] d;
  logic [31:0] v;
  initial forever #20 clk_sys_i = ~clk_sys_i;
  adc_conversion_control i_dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req),
    .rdata_o(rdata), .cmp_bit_i(cmp_bit), .conv_clock_o(conv_clk), .sample_o(smp),
    .converter_power_enable_o(pwr), .core_reset_o(crst), .route_o(route), .irq_o(irq));
  adc_analog_model i_ana (.clk_sys_i(clk_sys_i), .pwr_i(pwr), .route_i(route), .cmp_bit_o(cmp_bit));
  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] w);
    @(posedge clk_sys_i) req <= {a, w, 2'b10};
    @(posedge clk_sys_i) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [2:0] a, output logic [7:0] r);
    @(posedge clk_sys_i) req <= {a, 8'h00, 2'b01};
    @(posedge clk_sys_i) req.rd <= 1'b0;
    @(negedge clk_sys_i) r = rdata;
  endtask : rd
  function automatic logic [11:0] code(input logic [3:0] s, input logic [2:0] c);
    if (s == 4'h0 || s == 4'h4 || s[3:2] == 2'b11) return {12{c[0]}};
    return {12{s[0] && s[3:2] != 2'b10}};
  endfunction : code
  task automatic conv(input logic [3:0] s, input logic [2:0] c, input logic f, input logic [2:0] dv);
    logic [11:0] r;
    r = code(s, c);
    // external pins taken as analog inputs for source codes 0000, 0100 and 11xx
    wr(`REG_B_ADDR, {s, f, dv});
    wr(`REG_A_ADDR, {4'h2, 1'b0, c});
    repeat (4) @(posedge clk_sys_i);
    wr(`REG_A_ADDR, {4'ha, 1'b0, c});
    wr(`REG_A_ADDR, {4'h2, 1'b0, c});
    rd(`REG_A_ADDR, d);
    chk({7'h0, d[6]}, 8'h01);
    for (int n = 0; n < 3000 && d[6] !== 1'b0; n++) rd(`REG_A_ADDR, d);
    chk({7'h0, d[6]}, 8'h00);
    rd(`RES_HI_ADDR, d);
    chk(d, f ? {4'h0, r[11:8]} : r[11:4]);
    rd(`RES_LO_ADDR, d);
    chk(d, f ? r[7:0] : {r[3:0], 4'h0});
  endtask : conv
  task automatic final_report();
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  initial begin
    repeat (90000) @(posedge clk_sys_i);
    err_count++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge clk_sys_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (i < 3 || i > 5) begin
        rd(i[2:0], d);
        chk(d, 8'h00);
      end
    end
    for (int i = 0; i < 16; i++) begin
      v = $random(seed);
      wr(`REG_C_ADDR, {4'h0, v[8:7], 2'h0});
      repeat (2) @(negedge clk_sys_i);
      chk({6'h00, route.reference}, {6'h00, v[8:7]});
      conv(i[3:0], v[2:0], v[3], v[6:4]);
    end
    wr(`REG_A_ADDR, 8'h2b);
    repeat (3) @(posedge clk_sys_i);
    wr(`IRQ_CTRL_ADDR, 8'h00);
    wr(`IRQ_CTRL_ADDR, 8'h03);
    conv(4'h0, 3'h1, 1'b1, 3'h0);
    chk({7'h0, irq}, 8'h01);
    rd(`IRQ_CTRL_ADDR, d);
    chk(d, 8'h07);
    wr(`REG_A_ADDR, 8'h00);
    wr(`REG_A_ADDR, 8'h80);
    wr(`REG_A_ADDR, 8'h00);
    rd(`REG_A_ADDR, d);
    chk(d, 8'h00);
    rd(`RES_LO_ADDR, d);
    chk(d, 8'hff);
    wr(`IRQ_CTRL_ADDR, 8'h03);
    rd(`IRQ_CTRL_ADDR, d);
    chk(d, 8'h03);
    chk({7'h0, irq}, 8'h00);
    wr(`IRQ_CTRL_ADDR, 8'h01);
    conv(4'h5, 3'h0, 1'b0, 3'h1);
    chk({7'h0, irq}, 8'h00);
    rd(`IRQ_CTRL_ADDR, d);
    chk(d, 8'h05);
    final_report();
  end
endmodule : test_adc_conversion_control
